// [common/ascb_pkg.sv]
// Constants and types of the imaging front end setup register bank.
// Assumes one 25 MHz master clock domain and the eight-bit control port.
package ascb_pkg;

	// Control port widths
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;

	// Register addresses as seen on the control port
	localparam logic [5:0] ADDR_SETUP1    = 6'h01;
	localparam logic [5:0] ADDR_SETUP2    = 6'h02;
	localparam logic [5:0] ADDR_SETUP3    = 6'h03;
	localparam logic [5:0] ADDR_DEV_RESET = 6'h04;
	localparam logic [5:0] ADDR_CYC_RESET = 6'h05;

	// Reset values
	localparam logic [7:0] RST_SETUP1 = 8'h03;
	localparam logic [7:0] RST_SETUP2 = 8'h20;
	localparam logic [7:0] RST_SETUP3 = 8'h1F;

	// Implemented bits; the rest read as zero
	localparam logic [7:0] MASK_SETUP1 = 8'h7F;
	localparam logic [7:0] MASK_SETUP2 = 8'hEF;
	localparam logic [7:0] MASK_SETUP3 = 8'hFF;

	// Setup register one fields
	localparam int POS_POWER   = 0;
	localparam int POS_DOUBLE  = 1;
	localparam int POS_MONO    = 2;
	localparam int POS_BLKPD   = 3;
	localparam int POS_AMPOFS  = 4;
	localparam int POS_MAXSPD  = 6;
	// Setup register two fields
	localparam int POS_FORMAT  = 0;
	localparam int POS_INVERT  = 2;
	localparam int POS_EXTREF  = 3;
	localparam int POS_RANGE   = 5;
	localparam int POS_LATENCY = 6;
	// Setup register three fields
	localparam int POS_DACCODE = 0;
	localparam int POS_RSTADJ  = 4;
	localparam int POS_CHAN    = 6;

	// Master clock periods in one converter clock period
	localparam logic [1:0] MCLK_PER_ADC       = 2'h2;
	localparam logic [1:0] MCLK_PER_ADC_MODE3 = 2'h3;

	// Channel pick codes
	localparam logic [1:0] CHAN_RED      = 2'h0;
	localparam logic [1:0] CHAN_RESERVED = 2'h3;

	// Effect of the amplifier offset field
	typedef enum logic [1:0] {
		OFS_ZERO,
		OFS_POS,
		OFS_NEG
	} ascb_offset_t;

	// Control port write handshake
	typedef enum logic {
		PORT_IDLE,
		PORT_HELD
	} ascb_port_state_t;

	// Control port pins
	typedef struct packed {
		logic [5:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} ascb_port_t;

	// Effective setup seen by the analogue and output logic
	typedef struct packed {
		logic       power_active;
		logic       double_sample_enable;
		logic       mono;
		logic [3:0] block_disable_field;
		logic [1:0] amp_output_offset_select;
		logic       max_speed_mode_flag;
		logic [1:0] output_word_format;
		logic       output_invert;
		logic       external_clamp_ref;
		logic       clamp_dac_range;
		logic [1:0] output_latency_select;
		logic [3:0] clamp_dac_code;
		logic [1:0] reset_sample_timing_adjust;
		logic [1:0] mono_channel_pick;
	} ascb_cfg_t;

	// Values derived from the setup
	typedef struct packed {
		ascb_offset_t amp_offset;
		logic [2:0]   beats_per_word;
		logic [3:0]   latency_mclk;
	} ascb_derived_t;

endpackage

// [rtl/ascb_sync.sv]
// Two flip-flop synchroniser for a group of pin levels.
// Assumes the levels are quasi static around the edges that matter.
`timescale 1ns/1ns
module ascb_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_i,   // Master clock
	input  wire logic             rst_b_i, // Asynchronous reset, active low
	input  wire logic [WIDTH-1:0] d_i,     // Level from outside the domain
	output logic      [WIDTH-1:0] q_o      // Level safe to use
);

	logic [WIDTH-1:0] meta;

	// First stage feeds the second only
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta <= '0;
			q_o  <= '0;
		end else begin
			meta <= d_i;
			q_o  <= meta;
		end
	end

endmodule

// [rtl/ascb_bank.sv]
// Setup register bank of a three channel imaging front end.
// Assumes a host driving the parallel control port pins, and mode inputs from
// the rest of the device; all pins arrive asynchronous to clk_i.
//
// What this block does
// - Setup one bit 0 powers the device; zero means complete power down; default one.
// - Setup one bit 1 picks single ended or double sampling; default double.
// - Setup one bit 2 picks colour (0) or monochrome (1); default colour.
// - Setup one bit 3 lets the separate four-bit field disable single blocks.
// - Setup one bits 5:4 set amplifier offset: zero, zero, full positive, full negative.
// - Setup two bits 1:0 pick parallel, 8+6, 7+7 or four nibble output words.
// - Setup two bit 2 inverts the output code.
// - Setup two bit 3 powers down the clamp DAC and floats its output.
// - Setup two bit 5 sets clamp DAC range; default top reference.
// - Setup two bits 7:6 add zero to three converter periods of latency.
// - A converter period is two master clocks, three in the third mode.
// - Setup three bits 3:0 set the clamp DAC code; default all ones.
// - Setup three bits 5:4 shift the reset sampling instant; default normal.
// - Setup three bits 7:6 pick the monochrome channel; code three reserved.
// - Any write to the device reset register resets every internal cell.
// - Any write to the cycle reset register points the colour cycle at red.
// - Line sequential mode forces monochrome and the red channel internally.
`timescale 1ns/1ns
module ascb_bank (
	input  wire logic                  clk_i,                 // Master clock, 25 MHz
	input  wire logic                  rst_b_i,               // Asynchronous reset, active low
	input  wire ascb_pkg::ascb_port_t  port_i,                // Control port pins
	input  wire logic                  line_sequential_mode_i, // Line by line operation selected
	input  wire logic [3:0]            block_disable_field_i, // Per block disable bits
	input  wire logic                  mode3_i,               // Third operating mode in use
	output logic [7:0]                 port_rdata_o,          // Read data on the control port
	output ascb_pkg::ascb_cfg_t        cfg_o,                 // Effective setup
	output ascb_pkg::ascb_derived_t    derived_o,             // Decoded setup values
	output logic                       device_reset_o,        // One cycle reset for all cells
	output logic                       cycle_reset_o,         // One cycle colour cycle restart
	output logic                       reserved_write_o       // Sticky reserved code written
);

	// Reset release through two flip-flops
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// Pin inputs brought into the clock domain
	ascb_pkg::ascb_port_t port_s;
	logic                 line_seq_s;
	logic [3:0]           blk_dis_s;
	logic                 mode3_s;

	ascb_sync #(.WIDTH($bits(ascb_pkg::ascb_port_t) + 6)) u_sync (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.d_i     ({port_i, line_sequential_mode_i, block_disable_field_i, mode3_i}),
		.q_o     ({port_s, line_seq_s, blk_dis_s, mode3_s})
	);

	// Latency in master clocks for a latency code
	function automatic logic [3:0] lat_mclk(input logic [1:0] sel, input logic m3);
		logic [3:0] per;
		per = {2'h0, m3 ? ascb_pkg::MCLK_PER_ADC_MODE3 : ascb_pkg::MCLK_PER_ADC};
		lat_mclk = 4'(per * {2'h0, sel});
	endfunction

	// Transfers per output word for a format code
	function automatic logic [2:0] word_beats(input logic [1:0] fmt);
		unique case (fmt)
			2'h0: word_beats = 3'h1;
			2'h1: word_beats = 3'h2;
			2'h2: word_beats = 3'h2;
			2'h3: word_beats = 3'h4;
		endcase
	endfunction

	// Write handshake: one write per strobe assertion
	ascb_pkg::ascb_port_state_t state;
	ascb_pkg::ascb_port_state_t next_state;
	wire wr_take = (state == ascb_pkg::PORT_IDLE) && port_s.wr;

	always_comb begin
		next_state = state;
		unique case (state)
			ascb_pkg::PORT_IDLE: if (port_s.wr) next_state = ascb_pkg::PORT_HELD;
			ascb_pkg::PORT_HELD: if (!port_s.wr) next_state = ascb_pkg::PORT_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) state <= ascb_pkg::PORT_IDLE;
		else        state <= next_state;
	end

	// Address decode of a taken write
	wire hit_setup1 = wr_take && (port_s.addr == ascb_pkg::ADDR_SETUP1);
	wire hit_setup2 = wr_take && (port_s.addr == ascb_pkg::ADDR_SETUP2);
	wire hit_setup3 = wr_take && (port_s.addr == ascb_pkg::ADDR_SETUP3);
	wire hit_devrst = wr_take && (port_s.addr == ascb_pkg::ADDR_DEV_RESET);
	wire hit_cycrst = wr_take && (port_s.addr == ascb_pkg::ADDR_CYC_RESET);
	wire chan_bad   = port_s.wdata[ascb_pkg::POS_CHAN +: 2] == ascb_pkg::CHAN_RESERVED;

	// Stored setup registers
	logic [7:0] setup1;
	logic [7:0] setup2;
	logic [7:0] setup3;
	logic       soft_rst;

	// Device reset reloads defaults the cycle after the write
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) soft_rst <= 1'b0;
		else        soft_rst <= hit_devrst;
	end

	// Setup registers with defaults restored by either reset
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			setup1 <= ascb_pkg::RST_SETUP1;
			setup2 <= ascb_pkg::RST_SETUP2;
			setup3 <= ascb_pkg::RST_SETUP3;
		end else if (soft_rst) begin
			setup1 <= ascb_pkg::RST_SETUP1;
			setup2 <= ascb_pkg::RST_SETUP2;
			setup3 <= ascb_pkg::RST_SETUP3;
		end else begin
			if (hit_setup1) setup1 <= port_s.wdata & ascb_pkg::MASK_SETUP1;
			if (hit_setup2) setup2 <= port_s.wdata & ascb_pkg::MASK_SETUP2;
			if (hit_setup3) setup3 <= port_s.wdata & ascb_pkg::MASK_SETUP3;
		end
	end

	// Read mux; write-only and unmapped addresses read zero
	logic [7:0] rd_mux;

	always_comb begin
		unique case (port_s.addr)
			ascb_pkg::ADDR_SETUP1: rd_mux = setup1;
			ascb_pkg::ADDR_SETUP2: rd_mux = setup2;
			ascb_pkg::ADDR_SETUP3: rd_mux = setup3;
			default:               rd_mux = 8'h00;
		endcase
	end

	// Read data stands while the read strobe is held
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) port_rdata_o <= 8'h00;
		else        port_rdata_o <= port_s.rd ? rd_mux : 8'h00;
	end

	// Field extraction
	wire       f_power  = setup1[ascb_pkg::POS_POWER];
	wire       f_double = setup1[ascb_pkg::POS_DOUBLE];
	wire       f_mono   = setup1[ascb_pkg::POS_MONO];
	wire       f_blkpd  = setup1[ascb_pkg::POS_BLKPD];
	wire [1:0] f_ampofs = setup1[ascb_pkg::POS_AMPOFS +: 2];
	wire       f_maxspd = setup1[ascb_pkg::POS_MAXSPD];
	wire [1:0] f_format = setup2[ascb_pkg::POS_FORMAT +: 2];
	wire       f_invert = setup2[ascb_pkg::POS_INVERT];
	wire       f_extref = setup2[ascb_pkg::POS_EXTREF];
	wire       f_range  = setup2[ascb_pkg::POS_RANGE];
	wire [1:0] f_lat    = setup2[ascb_pkg::POS_LATENCY +: 2];
	wire [3:0] f_dac    = setup3[ascb_pkg::POS_DACCODE +: 4];
	wire [1:0] f_rstadj = setup3[ascb_pkg::POS_RSTADJ +: 2];
	wire [1:0] f_chan   = setup3[ascb_pkg::POS_CHAN +: 2];

	// Effective setup after internal forcing
	ascb_pkg::ascb_cfg_t next_cfg;

	always_comb begin
		next_cfg.power_active               = f_power;
		next_cfg.double_sample_enable       = f_double;
		next_cfg.mono                       = line_seq_s | f_mono;
		next_cfg.block_disable_field        = f_blkpd ? blk_dis_s : 4'h0;
		next_cfg.amp_output_offset_select   = f_ampofs;
		next_cfg.max_speed_mode_flag        = f_maxspd;
		next_cfg.output_word_format         = f_format;
		next_cfg.output_invert              = f_invert;
		next_cfg.external_clamp_ref         = f_extref;
		next_cfg.clamp_dac_range            = f_range;
		next_cfg.output_latency_select      = f_lat;
		next_cfg.clamp_dac_code             = f_dac;
		next_cfg.reset_sample_timing_adjust = f_rstadj;
		next_cfg.mono_channel_pick          = line_seq_s ? ascb_pkg::CHAN_RED : f_chan;
	end

	// Decoded values for the datapath
	ascb_pkg::ascb_derived_t next_der;

	always_comb begin
		next_der.amp_offset     = f_ampofs == 2'h2 ? ascb_pkg::OFS_POS :
			(f_ampofs == 2'h3 ? ascb_pkg::OFS_NEG : ascb_pkg::OFS_ZERO);
		next_der.beats_per_word = word_beats(f_format);
		next_der.latency_mclk   = lat_mclk(f_lat, mode3_s);
	end

	// Registered outputs
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cfg_o            <= '0;
			derived_o        <= '0;
			device_reset_o   <= 1'b0;
			cycle_reset_o    <= 1'b0;
			reserved_write_o <= 1'b0;
		end else begin
			cfg_o            <= next_cfg;
			derived_o        <= next_der;
			device_reset_o   <= hit_devrst;
			cycle_reset_o    <= hit_cycrst;
			reserved_write_o <= (reserved_write_o & ~soft_rst) | (hit_setup3 & chan_bad);
		end
	end

	// Checks

	a_dev_reset_dflt: assert property (@(posedge clk_i) disable iff (!rst_n)
		hit_devrst |-> ##2 (setup1 == ascb_pkg::RST_SETUP1 && setup3 == ascb_pkg::RST_SETUP3))
		else $error("setup not restored after device reset");

	a_power_follow: assert property (@(posedge clk_i) disable iff (!rst_n)
		hit_setup1 && !soft_rst |-> ##2 cfg_o.power_active == $past(port_s.wdata[0], 2))
		else $error("power bit did not follow write");

	a_double_follow: assert property (@(posedge clk_i) disable iff (!rst_n)
		hit_setup1 && !soft_rst |-> ##2 cfg_o.double_sample_enable == $past(port_s.wdata[1], 2))
		else $error("sampling mode did not follow write");

	a_line_forces: assert property (@(posedge clk_i) disable iff (!rst_n)
		$past(line_seq_s) |-> (cfg_o.mono && cfg_o.mono_channel_pick == 2'h0))
		else $error("line mode did not force mono red");

	a_block_gate: assert property (@(posedge clk_i) disable iff (!rst_n)
		cfg_o.block_disable_field != 4'h0 |-> $past(setup1[3]))
		else $error("block disable passed while gate off");

	a_latency_mode3: assert property (@(posedge clk_i) disable iff (!rst_n)
		$past(mode3_s) && $past(setup2[7:6]) == 2'h3 |-> derived_o.latency_mclk == 4'h9)
		else $error("latency in mode three wrong");

	a_latency_norm: assert property (@(posedge clk_i) disable iff (!rst_n)
		!$past(mode3_s) && $past(setup2[7:6]) == 2'h2 |-> derived_o.latency_mclk == 4'h4)
		else $error("latency in normal modes wrong");

	a_cycle_pulse: assert property (@(posedge clk_i) disable iff (!rst_n)
		hit_cycrst |=> cycle_reset_o ##1 !cycle_reset_o)
		else $error("cycle reset not a single pulse");

	a_nibble_beats: assert property (@(posedge clk_i) disable iff (!rst_n)
		$past(setup2[1:0]) == 2'h3 |-> derived_o.beats_per_word == 3'h4)
		else $error("nibble format beat count wrong");

	a_reserved_flag: assert property (@(posedge clk_i) disable iff (!rst_n)
		hit_setup3 && chan_bad |=> reserved_write_o)
		else $error("reserved channel write not flagged");

endmodule

// [test/ascb_host.sv]
// Host controller model that drives the setup bank control port pins.
// Assumes the bank syncs the pins to clk_i and answers a read three edges later.
`timescale 1ns/1ns
module ascb_host (
	input  wire logic            clk_i,   // Master clock
	input  wire logic [7:0]      rdata_i, // Read data from the bank
	output ascb_pkg::ascb_port_t port_o   // Control port pins
);
	logic max_speed_mode = 1'b0; // Fourth operating mode in use

	// Port idle at time zero
	initial port_o = '0;

	// Address and data settle two cycles before the strobe rises
	task automatic write_reg(input logic [5:0] a, input logic [7:0] d, input int hold);
		logic [7:0] v;
		v = d;
		if (a == ascb_pkg::ADDR_SETUP1) v[ascb_pkg::POS_MAXSPD] = max_speed_mode;
		@(posedge clk_i);
		port_o.addr <= a;
		port_o.wdata <= v;
		repeat (2) @(posedge clk_i);
		port_o.wr <= 1'b1;
		repeat (hold) @(posedge clk_i);
		port_o.wr <= 1'b0;
		@(posedge clk_i);
		// Released lines show the inverse, not a stale value
		port_o.addr <= ~a;
		port_o.wdata <= ~v;
		repeat (3) @(posedge clk_i);
	endtask

	// Read data is taken while the strobe is still held
	task automatic read_reg(input logic [5:0] a, output logic [7:0] d);
		@(posedge clk_i);
		port_o.addr <= a;
		port_o.rd <= 1'b1;
		repeat (4) @(posedge clk_i);
		d = rdata_i;
		port_o.rd <= 1'b0;
		port_o.addr <= ~a;
		repeat (4) @(posedge clk_i);
	endtask
endmodule

// [test/tb.sv]
// Self-checking bench for the setup register bank.
// Assumes the host model drives the control port; mode pins come from here.
`timescale 1ns/1ns
module tb;
	logic                    clk = 1'b0;
	logic                    rst_b = 1'b0;
	logic                    line_mode = 1'b0;
	logic [3:0]              blk_dis = 4'hA;
	logic                    mode3 = 1'b0;
	ascb_pkg::ascb_port_t    port;
	logic [7:0]              rdata;
	ascb_pkg::ascb_cfg_t     cfg;
	ascb_pkg::ascb_derived_t der;
	logic                    dev_rst;
	logic                    cyc_rst;
	logic                    rsv;
	logic [7:0]              v;
	int                      fail_count = 0;
	int                      total_checks = 0;
	int                      dev_n = 0;
	int                      cyc_n = 0;

	// Master clock, 40 ns period
	always #20 clk = ~clk;

	ascb_host u_host (.clk_i(clk), .rdata_i(rdata), .port_o(port));

	ascb_bank u_dut (
		.clk_i                  (clk),
		.rst_b_i                (rst_b),
		.port_i                 (port),
		.line_sequential_mode_i (line_mode),
		.block_disable_field_i  (blk_dis),
		.mode3_i                (mode3),
		.port_rdata_o           (rdata),
		.cfg_o                  (cfg),
		.derived_o              (der),
		.device_reset_o         (dev_rst),
		.cycle_reset_o          (cyc_rst),
		.reserved_write_o       (rsv)
	);

	// Count the one-cycle strobes
	always @(posedge clk) begin
		if (dev_rst === 1'b1) dev_n++;
		if (cyc_rst === 1'b1) cyc_n++;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Defaults after reset, and reads of empty or write-only places
	task automatic t_defaults();
		u_host.read_reg(ascb_pkg::ADDR_SETUP1, v);
		check(v, 8'h03, "setup1 default");
		u_host.read_reg(ascb_pkg::ADDR_SETUP2, v);
		check(v, 8'h20, "setup2 default");
		u_host.read_reg(ascb_pkg::ADDR_SETUP3, v);
		check(v, 8'h1F, "setup3 default");
		check({7'h00, cfg.double_sample_enable}, 8'h01, "double default");
		check({7'h00, cfg.mono}, 8'h00, "colour default");
		check({6'h00, cfg.reset_sample_timing_adjust}, 8'h01, "timing default");
		u_host.read_reg(6'h06, v);
		check(v, 8'h00, "unmapped read");
		u_host.read_reg(ascb_pkg::ADDR_DEV_RESET, v);
		check(v, 8'h00, "write-only read");
		$display("t_defaults done");
	endtask

	// Every offset code, with per-block disable on, then the fourth mode
	task automatic t_setup1();
		ascb_pkg::ascb_offset_t ofs[4];
		ofs = '{ascb_pkg::OFS_ZERO, ascb_pkg::OFS_ZERO, ascb_pkg::OFS_POS, ascb_pkg::OFS_NEG};
		for (int i = 0; i < 4; i++) begin
			u_host.write_reg(ascb_pkg::ADDR_SETUP1, {2'h0, 2'(i), 4'h8}, 3);
			check({6'h00, der.amp_offset}, {6'h00, ofs[i]}, "amp offset");
			check({6'h00, cfg.amp_output_offset_select}, {6'h00, 2'(i)}, "offset field");
			check({4'h0, cfg.block_disable_field}, 8'h0A, "block disable");
			check({7'h00, cfg.power_active}, 8'h00, "power down");
			check({7'h00, cfg.double_sample_enable}, 8'h00, "single ended");
		end
		u_host.max_speed_mode = 1'b1;
		u_host.write_reg(ascb_pkg::ADDR_SETUP1, 8'h05, 3);
		u_host.max_speed_mode = 1'b0;
		check({7'h00, cfg.max_speed_mode_flag}, 8'h01, "max speed flag");
		check({7'h00, cfg.mono}, 8'h01, "mono");
		check({4'h0, cfg.block_disable_field}, 8'h00, "no block control");
		u_host.read_reg(ascb_pkg::ADDR_SETUP1, v);
		check(v, 8'h45, "setup1 readback");
		$display("t_setup1 done");
	endtask

	// Every format and latency, in both converter clock ratios
	task automatic t_setup2();
		logic [2:0] beats[4];
		beats = '{3'h1, 3'h2, 3'h2, 3'h4};
		for (int i = 0; i < 4; i++) begin
			u_host.write_reg(ascb_pkg::ADDR_SETUP2, {2'(i), 4'h3, 2'(i)}, 3);
			check({5'h00, der.beats_per_word}, {5'h00, beats[i]}, "beats");
			check({6'h00, cfg.output_word_format}, {6'h00, 2'(i)}, "format field");
			check({6'h00, cfg.output_latency_select}, {6'h00, 2'(i)}, "latency field");
			check({4'h0, der.latency_mclk}, 8'(i * 2), "latency");
			check({6'h00, cfg.output_invert, cfg.external_clamp_ref}, 8'h03, "invert and ext");
			check({7'h00, cfg.clamp_dac_range}, 8'h00, "dac range");
			mode3 <= 1'b1;
			u_host.read_reg(ascb_pkg::ADDR_SETUP2, v);
			check(v, {2'(i), 4'h3, 2'(i)}, "setup2 readback");
			check({4'h0, der.latency_mclk}, 8'(i * 3), "latency mode3");
			mode3 <= 1'b0;
		end
		$display("t_setup2 done");
	endtask

	// Clamp code, timing, channel pick, reserved code and line mode
	task automatic t_setup3();
		u_host.write_reg(ascb_pkg::ADDR_SETUP3, 8'hA6, 3);
		check({4'h0, cfg.clamp_dac_code}, 8'h06, "dac code");
		check({6'h00, cfg.reset_sample_timing_adjust}, 8'h02, "timing");
		check({6'h00, cfg.mono_channel_pick}, 8'h02, "channel");
		check({7'h00, rsv}, 8'h00, "no reserved");
		u_host.write_reg(ascb_pkg::ADDR_SETUP3, 8'hE6, 3);
		check({7'h00, rsv}, 8'h01, "reserved flagged");
		line_mode <= 1'b1;
		u_host.read_reg(ascb_pkg::ADDR_SETUP3, v);
		check(v, 8'hE6, "setup3 readback");
		check({5'h00, cfg.mono, cfg.mono_channel_pick}, 8'h04, "line forcing");
		line_mode <= 1'b0;
		$display("t_setup3 done");
	endtask

	// Strobes give one pulse per write, device reset restores defaults
	task automatic t_strobes();
		u_host.write_reg(ascb_pkg::ADDR_CYC_RESET, 8'h5A, 8);
		check(8'(cyc_n), 8'h01, "cycle pulse");
		check(8'(dev_n), 8'h00, "no device pulse");
		u_host.write_reg(ascb_pkg::ADDR_SETUP2, 8'hC7, 3);
		u_host.write_reg(ascb_pkg::ADDR_DEV_RESET, 8'h00, 3);
		check(8'(dev_n), 8'h01, "device pulse");
		check({7'h00, rsv}, 8'h00, "reserved cleared");
		u_host.read_reg(ascb_pkg::ADDR_SETUP1, v);
		check(v, 8'h03, "setup1 restored");
		u_host.read_reg(ascb_pkg::ADDR_SETUP2, v);
		check(v, 8'h20, "setup2 restored");
		u_host.read_reg(ascb_pkg::ADDR_SETUP3, v);
		check(v, 8'h1F, "setup3 restored");
		$display("t_strobes done");
	endtask

	// Main sequence
	initial begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		repeat (6) @(posedge clk);
		t_defaults();
		t_setup1();
		t_setup2();
		t_setup3();
		t_strobes();
		complete_run();
	end

	// Watchdog, far beyond the three hundred or so cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		complete_run();
	end
endmodule
